//--- core/sfdp_table_read.v
// Purpose: serial command logic answering the discoverable-parameter table read
// Assumes: spi mode 0 or 3; pins are oversampled by clk (100 MHz), much faster than sclk
// Notes: bodies of the parameter tables and unique id read as body_fill
//
// Function
// - opcode 5Ah after chip select falls starts a table read
// - 24-bit address then one dummy byte, all sampled on rising clock
// - after the dummy byte, table bytes leave msb first on falling clock
// - any table byte may be the start address
// - address advances by one after every byte shifted out
// - address wraps to zero after the top and output continues
// - chip select high ends the read and releases the data output
// - read during erase, program or status write is rejected, cycle untouched
// - table space is 512 bytes, unique id included
// - bytes 00h-03h read 53h 46h 44h 50h
// - byte 04h holds minor revision 06h
// - byte 05h holds major revision 01h
// - byte 06h header count 02h; bytes 07h 0Fh 17h 1Fh read FFh
// - first header: id 00h, rev 06h/01h, 10h dwords, pointer 000030h
// - second header: maker id, rev 00h/01h, 04h dwords, pointer 10h 01h 00h
// - third header: id 84h, rev 00h/01h, 02h dwords, pointer C0h 00h 00h
`include "sfdp_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module sfdp_table_read #(
  parameter [7:0] maker_id = 8'hA5, // arbitrary neutral value
  parameter [7:0] body_fill = 8'hFF
) (
  input wire clk,
  input wire reset,
  input wire sclk,
  input wire cs_n,
  input wire mosi,
  input wire write_busy,
  output reg miso_q,
  output reg miso_oe_n_q,
  output reg read_active_q
);

  localparam [2:0] st_idle = 3'b000;
  localparam [2:0] st_opcode = 3'b001;
  localparam [2:0] st_addr = 3'b010;
  localparam [2:0] st_dummy = 3'b011;
  localparam [2:0] st_data = 3'b100;
  localparam [2:0] st_ignore = 3'b101;

  // three-stage sampling of the pins; level taken once stages two and three agree
  reg [2:0] sclk_s_q;
  reg [2:0] cs_s_q;
  reg [2:0] mosi_s_q;
  reg sclk_f_q;
  reg cs_n_f_q;
  reg mosi_f_q;
  reg [2:0] state_q;
  reg [4:0] bit_cnt_q;
  reg [7:0] opc_q;
  reg [`SFDP_ADDR_BITS-1:0] addr_q;
  reg [7:0] shift_q;
  reg [2:0] out_cnt_q;

  wire sclk_ok;
  wire cs_ok;
  wire mosi_ok;
  wire sclk_rise;
  wire sclk_fall;
  wire cs_fall;
  wire cs_rise;
  wire mosi_bit;
  wire [7:0] opc_full;
  wire [`SFDP_ADDR_BITS-1:0] addr_full;
  wire [`SFDP_ADDR_BITS-1:0] addr_next;

  assign sclk_ok = (sclk_s_q[1] == sclk_s_q[2]);
  assign cs_ok = (cs_s_q[1] == cs_s_q[2]);
  assign mosi_ok = (mosi_s_q[1] == mosi_s_q[2]);
  assign sclk_rise = sclk_ok && sclk_s_q[2] && !sclk_f_q;
  assign sclk_fall = sclk_ok && !sclk_s_q[2] && sclk_f_q;
  assign cs_fall = cs_ok && !cs_s_q[2] && cs_n_f_q;
  assign cs_rise = cs_ok && cs_s_q[2] && !cs_n_f_q;
  assign mosi_bit = mosi_ok ? mosi_s_q[2] : mosi_f_q;
  assign opc_full = {opc_q[6:0], mosi_bit};
  assign addr_full = {addr_q[`SFDP_ADDR_BITS-2:0], mosi_bit};
  assign addr_next = addr_q + {{(`SFDP_ADDR_BITS-1){1'b0}}, 1'b1};

  // table contents, 512 bytes addressed by the low address bits
  function [7:0] table_byte;
    input [`SFDP_ADDR_BITS-1:0] a;
    begin
      if (a[`SFDP_ADDR_BITS-1:5] != 4'h0) begin
        table_byte = body_fill;
      end else begin
        case (a[4:0])
          5'h00: table_byte = `SFDP_SIG0;
          5'h01: table_byte = `SFDP_SIG1;
          5'h02: table_byte = `SFDP_SIG2;
          5'h03: table_byte = `SFDP_SIG3;
          5'h04: table_byte = `SFDP_REV_MINOR;
          5'h05: table_byte = `SFDP_REV_MAJOR;
          5'h06: table_byte = `SFDP_HEADER_COUNT;
          5'h08: table_byte = `SFDP_H0_ID;
          5'h09: table_byte = `SFDP_H0_MINOR;
          5'h0A: table_byte = `SFDP_H0_MAJOR;
          5'h0B: table_byte = `SFDP_H0_LEN;
          5'h0C: table_byte = `SFDP_H0_PTR0;
          5'h0D: table_byte = `SFDP_H0_PTR1;
          5'h0E: table_byte = `SFDP_H0_PTR2;
          5'h10: table_byte = maker_id;
          5'h11: table_byte = `SFDP_H1_MINOR;
          5'h12: table_byte = `SFDP_H1_MAJOR;
          5'h13: table_byte = `SFDP_H1_LEN;
          5'h14: table_byte = `SFDP_H1_PTR0;
          5'h15: table_byte = `SFDP_H1_PTR1;
          5'h16: table_byte = `SFDP_H1_PTR2;
          5'h18: table_byte = `SFDP_H2_ID;
          5'h19: table_byte = `SFDP_H2_MINOR;
          5'h1A: table_byte = `SFDP_H2_MAJOR;
          5'h1B: table_byte = `SFDP_H2_LEN;
          5'h1C: table_byte = `SFDP_H2_PTR0;
          5'h1D: table_byte = `SFDP_H2_PTR1;
          5'h1E: table_byte = `SFDP_H2_PTR2;
          default: table_byte = `SFDP_UNUSED;
        endcase
      end
    end
  endfunction

  always @(posedge clk) begin
    if (reset) begin
      sclk_s_q <= 3'h0;
      cs_s_q <= 3'h7;
      mosi_s_q <= 3'h0;
      sclk_f_q <= 1'b0;
      cs_n_f_q <= 1'b1;
      mosi_f_q <= 1'b0;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], sclk};
      cs_s_q <= {cs_s_q[1:0], cs_n};
      mosi_s_q <= {mosi_s_q[1:0], mosi};
      if (sclk_ok) begin
        sclk_f_q <= sclk_s_q[2];
      end
      if (cs_ok) begin
        cs_n_f_q <= cs_s_q[2];
      end
      if (mosi_ok) begin
        mosi_f_q <= mosi_s_q[2];
      end
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      state_q <= st_idle;
      bit_cnt_q <= 5'h00;
      opc_q <= 8'h00;
      addr_q <= {`SFDP_ADDR_BITS{1'b0}};
      shift_q <= 8'h00;
      out_cnt_q <= 3'h0;
      miso_q <= 1'b0;
      miso_oe_n_q <= 1'b1;
      read_active_q <= 1'b0;
    end else if (cs_rise) begin
      state_q <= st_idle;
      miso_oe_n_q <= 1'b1;
      read_active_q <= 1'b0;
    end else if (cs_fall) begin
      state_q <= st_opcode;
      bit_cnt_q <= 5'h00;
    end else begin
      case (state_q)
        st_opcode: begin
          if (sclk_rise) begin
            opc_q <= opc_full;
            bit_cnt_q <= bit_cnt_q + 5'h01;
            if (bit_cnt_q == `SFDP_OPC_BITS) begin
              bit_cnt_q <= 5'h00;
              if (opc_full == `SFDP_OPCODE && !write_busy) begin
                state_q <= st_addr;
                read_active_q <= 1'b1;
              end else begin
                state_q <= st_ignore;
              end
            end
          end
        end
        st_addr: begin
          if (sclk_rise) begin
            addr_q <= addr_full;
            bit_cnt_q <= bit_cnt_q + 5'h01;
            if (bit_cnt_q == `SFDP_ADDR_LAST_BIT) begin
              bit_cnt_q <= 5'h00;
              state_q <= st_dummy;
            end
          end
        end
        st_dummy: begin
          if (sclk_rise) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
            if (bit_cnt_q == `SFDP_DUMMY_BITS) begin
              state_q <= st_data;
              shift_q <= table_byte(addr_q);
              out_cnt_q <= 3'h0;
            end
          end
        end
        st_data: begin
          if (sclk_fall) begin
            miso_q <= shift_q[7];
            miso_oe_n_q <= 1'b0;
            out_cnt_q <= out_cnt_q + 3'h1;
            if (out_cnt_q == `SFDP_BYTE_LAST_BIT) begin
              addr_q <= addr_next;
              shift_q <= table_byte(addr_next);
            end else begin
              shift_q <= {shift_q[6:0], 1'b0};
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

endmodule // sfdp_table_read

`default_nettype wire

//--- pkg/sfdp_defines.vh
// Purpose: constants of the discoverable-parameter table read
// Assumes: single-bit serial mode, 3-byte addressing
// Notes: table bodies past the headers read as the fill value
`ifndef SFDP_DEFINES_VH
`define SFDP_DEFINES_VH

`define SFDP_OPCODE 8'h5A
`define SFDP_ADDR_BITS 9
`define SFDP_OPC_BITS 5'h07
`define SFDP_ADDR_LAST_BIT 5'h17
`define SFDP_DUMMY_BITS 5'h07
`define SFDP_BYTE_LAST_BIT 3'h7

`define SFDP_SIG0 8'h53
`define SFDP_SIG1 8'h46
`define SFDP_SIG2 8'h44
`define SFDP_SIG3 8'h50
`define SFDP_REV_MINOR 8'h06
`define SFDP_REV_MAJOR 8'h01
`define SFDP_HEADER_COUNT 8'h02
`define SFDP_UNUSED 8'hFF

`define SFDP_H0_ID 8'h00
`define SFDP_H0_MINOR 8'h06
`define SFDP_H0_MAJOR 8'h01
`define SFDP_H0_LEN 8'h10
`define SFDP_H0_PTR0 8'h30
`define SFDP_H0_PTR1 8'h00
`define SFDP_H0_PTR2 8'h00

`define SFDP_H1_MINOR 8'h00
`define SFDP_H1_MAJOR 8'h01
`define SFDP_H1_LEN 8'h04
`define SFDP_H1_PTR0 8'h10
`define SFDP_H1_PTR1 8'h01
`define SFDP_H1_PTR2 8'h00

`define SFDP_H2_ID 8'h84
`define SFDP_H2_MINOR 8'h00
`define SFDP_H2_MAJOR 8'h01
`define SFDP_H2_LEN 8'h02
`define SFDP_H2_PTR0 8'hC0
`define SFDP_H2_PTR1 8'h00
`define SFDP_H2_PTR2 8'h00

`endif

//--- testbench/sfd_table_read_properties.sv
// Purpose: port checks for the table read block
// Assumes: host half periods of 8 clk, sclk counted raw at the pin
// Notes: bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
module sfd_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic write_busy,
  input wire logic miso_q,
  input wire logic miso_oe_n_q,
  input wire logic read_active_q
);
  logic [7:0] rise_q;
  logic sclk_q;
  always_ff @(posedge clk) begin
    sclk_q <= sclk;
    if (reset || cs_n) rise_q <= 8'h00;
    else if (sclk && !sclk_q && rise_q != 8'hFF) rise_q <= rise_q + 8'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_opc; $rose(read_active_q) |-> rise_q == 8'h08; endproperty
  property p_first; $fell(miso_oe_n_q) |-> rise_q == 8'h28; endproperty
  property p_oe; !miso_oe_n_q |-> read_active_q; endproperty
  property p_edge; $changed(miso_q) && !miso_oe_n_q && $past(!miso_oe_n_q) |-> !$past(sclk, 2); endproperty
  property p_end; $rose(cs_n) |-> ##[1:6] !read_active_q && miso_oe_n_q; endproperty
  property p_idle; cs_n [*6] |-> miso_oe_n_q && !read_active_q; endproperty
  property p_busy; $rose(read_active_q) |-> !$past(write_busy); endproperty
  property p_rst; $fell(reset) |-> miso_oe_n_q && !read_active_q; endproperty
  a_opc: assert property (p_opc) else $error("read began off the opcode boundary");
  a_first: assert property (p_first) else $error("data began off the dummy boundary");
  a_oe: assert property (p_oe) else $error("data driven outside a read");
  a_edge: assert property (p_edge) else $error("data changed away from a falling sclk");
  a_end: assert property (p_end) else $error("read not ended by chip select");
  a_idle: assert property (p_idle) else $error("output driven while deselected");
  a_busy: assert property (p_busy) else $error("read accepted while busy");
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  c_read: cover property ($rose(read_active_q));
  c_data: cover property ($fell(miso_oe_n_q));
  c_busy: cover property (write_busy && !cs_n);
endmodule // sfd_props
bind sfdp_table_read sfd_props u_props (.clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
  .write_busy(write_busy), .miso_q(miso_q), .miso_oe_n_q(miso_oe_n_q), .read_active_q(read_active_q));
`default_nettype wire

//--- testbench/sfd_host.sv
// Purpose: host controller model, spi mode 0
// Assumes: half period of 8 clk
// Notes: data line toggles when its value does not matter
`timescale 1ns/1ps
`default_nettype none
module sfd_host (
  input wire logic clk,
  input wire logic miso,
  output logic sclk,
  output logic cs_n,
  output logic mosi
);
  logic [7:0] rx[$];
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic half();
    repeat (8) @(posedge clk);
  endtask
  task automatic step(input logic b, output logic r);
    mosi <= b;
    half();
    sclk <= 1'b1;
    r = miso;
    half();
    sclk <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] op, input logic [23:0] adr, input logic [7:0] dmy, input int n, input int tail);
    logic [39:0] sh;
    logic [7:0] b;
    logic r;
    sh = {op, adr, dmy};
    b = 8'h00;
    rx.delete();
    @(posedge clk);
    cs_n <= 1'b0;
    half();
    for (int i = 39; i >= 0; i--) step(sh[i], r);
    for (int k = 0; k < n * 8 + tail; k++) begin
      step(~mosi, r);
      b = {b[6:0], r};
      if (k % 8 == 7) rx.push_back(b);
    end
    half();
    cs_n <= 1'b1;
    mosi <= ~mosi;
    half();
  endtask
endmodule // sfd_host
`default_nettype wire

//--- testbench/tb_top.sv
// Purpose: self-checking bench for the table read block
// Assumes: host model drives the pins, bench drives reset and busy
// Notes: table bodies set to a distinct fill
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [7:0] MKR = 8'h3C; // arbitrary maker code
  localparam logic [7:0] FILL = 8'hC3;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic write_busy = 1'b0;
  int low_cnt = 0;
  wire sclk, cs_n, mosi, miso, oe_n, act;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  sfdp_table_read #(.maker_id(MKR), .body_fill(FILL)) DUT (.clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .write_busy(write_busy), .miso_q(miso), .miso_oe_n_q(oe_n), .read_active_q(act));
  sfd_host host (.clk(clk), .miso(miso), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));
  function automatic logic [7:0] tbl(input logic [8:0] a);
    logic [7:0] t [0:31];
    t = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01, 8'h02, 8'hFF, 8'h00, 8'h06, 8'h01, 8'h10, 8'h30, 8'h00, 8'h00,
      8'hFF, MKR, 8'h00, 8'h01, 8'h04, 8'h10, 8'h01, 8'h00, 8'hFF, 8'h84, 8'h00, 8'h01, 8'h02, 8'hC0, 8'h00, 8'h00, 8'hFF};
    return (a < 9'h020) ? t[a[4:0]] : FILL;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    if (err_total == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!oe_n) low_cnt <= low_cnt + 1;
    if (cyc == 30000) begin
      err_total++;
      test_done();
    end
  end
  task automatic t_header();
    host.cmd(8'h5A, 24'h00_0000, 8'hA5, 32, 0);
    for (int i = 0; i < 32; i++) chk(host.rx[i], tbl(i[8:0]));
  endtask
  task automatic t_wrap();
    host.cmd(8'h5A, 24'h00_01FE, 8'h00, 4, 0);
    for (int i = 0; i < 4; i++) chk(host.rx[i], tbl(9'h1FE + i[8:0]));
    host.cmd(8'h5A, 24'h00_0013, 8'hFF, 2, 0);
    for (int i = 0; i < 2; i++) chk(host.rx[i], tbl(9'h013 + i[8:0]));
  endtask
  task automatic t_abort();
    host.cmd(8'h5A, 24'h00_0010, 8'h00, 1, 3);
    chk(host.rx[0], MKR);
    chk({6'h00, oe_n, act}, 8'h02);
  endtask
  task automatic t_refuse();
    int base;
    @(posedge clk);
    base = low_cnt;
    write_busy <= 1'b1;
    host.cmd(8'h5A, 24'h00_0000, 8'h00, 1, 0);
    @(posedge clk);
    write_busy <= 1'b0;
    chk((low_cnt == base) ? 8'h00 : 8'h01, 8'h00);
    host.cmd(8'h03, 24'h00_0000, 8'h00, 1, 0);
    chk((low_cnt == base) ? 8'h00 : 8'h01, 8'h00);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    t_header();
    t_wrap();
    t_refuse();
    t_abort();
    test_done();
  end
endmodule // tb_top
`default_nettype wire
